/* logic/ccd_pkg.sv */
// Package for the configuration command decoder: opcodes, sizes, timing, carriers
package ccd_pkg;
  localparam logic [7:0] OP_JUMP = 8'h7e;
  localparam logic [7:0] OP_FLASH_BRIDGE = 8'h3a;
  localparam logic [7:0] OP_PORT_WIDTH = 8'hd9;
  localparam logic [7:0] OP_BANK_RELEASE = 8'h54;
  localparam logic [7:0] OP_PUBKEY_PROG = 8'h59;
  localparam logic [7:0] OP_PUBKEY_READ = 8'h5a;
  localparam logic [7:0] OP_SEC_BOOT = 8'h7f;
  localparam logic [7:0] OP_DRYRUN_SIG = 8'h5d;
  localparam logic [7:0] OP_BUSY_POLL = 8'hf0;
  localparam logic [7:0] OP_RESTART = 8'h79;
  localparam int IR_W = 8;
  localparam int OPND_W = 24;
  localparam int SEC_BOOT_W = 32;
  localparam int PUBKEY_W = 32;
  localparam int DR_W = 32;
  // Operand fields
  localparam int BANK_RIGHT_BIT = 1;
  localparam int BANK_LEFT_BIT = 0;
  localparam logic [1:0] WIDTH_SINGLE = 2'h0;
  localparam logic [1:0] WIDTH_DUAL = 2'h1;
  localparam logic [1:0] WIDTH_QUAD = 2'h2;
  localparam int WIDTH_LSB = 0;
  // Reset values
  localparam logic [SEC_BOOT_W-1:0] SEC_BOOT_RST = 32'h0000_0000;
  localparam logic [IR_W-1:0] IR_RST = 8'h30;
  // Timing
  localparam int CLK_MHZ = 25;
  localparam int RESTART_PULSE_NS = 200;
  localparam int RESTART_CYC = (RESTART_PULSE_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } ccd_tap_in_s;

  typedef struct packed {
    logic done;
    logic [PUBKEY_W-1:0] data;
  } ccd_nv_rsp_s;

  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAU_DR, TS_EX2_DR,
    TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
  } ccd_tap_e;
endpackage : ccd_pkg

/* logic/ccd_decoder.sv */
// Configuration command decoder behind the test port
`timescale 1ns/100ps
// Overview of operation
// - Opcode 7E loads its 24-bit operand as the new boot memory fetch address.
// - Opcode 3A connects the host flash port through to on-chip flash, a long operation.
// - Opcode D9 sets the slave serial port to single, dual or quad width per operand.
// - Opcode 54 releases right banks on operand bit 1 and left banks on operand bit 0.
// - Opcode 59 programs the signature public key as a delayed, polled operation.
// - Opcode 5A returns the stored public key to the host.
// - Opcode 7F takes 32 data bits to replace the default secondary boot address.
// - Opcode 5D shifts out the dry-run user signature shadow register.
// - A loaded instruction executes on the first test-clock rise in Run-Test/Idle, or is dropped if busy is set then.
// - A nullified instruction acts on nothing yet keeps its register in the scan path.
// - Opcode 79 restarts configuration as if the program request pin were toggled.
module ccd_decoder (
  input wire logic clock,
  input wire logic rst,
  input wire ccd_pkg::ccd_tap_in_s tap_in,
  output logic tdo,
  output logic tdo_oe,
  input wire logic nullify,
  input wire logic [ccd_pkg::PUBKEY_W-1:0] dryrun_sig,
  input wire ccd_pkg::ccd_nv_rsp_s nv_rsp,
  output logic nv_prog_start,
  output logic [ccd_pkg::PUBKEY_W-1:0] nv_prog_data,
  output logic flash_bridge_en,
  output logic [ccd_pkg::OPND_W-1:0] boot_addr,
  output logic boot_jump,
  output logic [1:0] serial_port_width,
  output logic bank_right_release,
  output logic bank_left_release,
  output logic [ccd_pkg::SEC_BOOT_W-1:0] sec_boot_addr,
  output logic restart_req,
  output logic busy
);
  import ccd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and test clock edge detect
  logic [2:0] sync1_ff, sync2_ff;
  logic tck_d_ff;
  logic tck_rise, tck_fall, tms_s, tdi_s;
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      tck_d_ff <= 1'b0;
    end else begin
      sync1_ff <= tap_in;
      sync2_ff <= sync1_ff;
      tck_d_ff <= sync2_ff[2];
    end
  end
  assign tck_rise = sync2_ff[2] & ~tck_d_ff;
  assign tck_fall = ~sync2_ff[2] & tck_d_ff;
  assign tms_s = sync2_ff[1];
  assign tdi_s = sync2_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // Test controller
  ccd_tap_e tap_ff, nxt_tap;
  always_comb begin
    nxt_tap = tap_ff;
    if (tck_rise) begin
      case (tap_ff)
        TS_RESET: nxt_tap = tms_s ? TS_RESET : TS_IDLE;
        TS_IDLE: nxt_tap = tms_s ? TS_SEL_DR : TS_IDLE;
        TS_SEL_DR: nxt_tap = tms_s ? TS_SEL_IR : TS_CAP_DR;
        TS_CAP_DR: nxt_tap = tms_s ? TS_EX1_DR : TS_SH_DR;
        TS_SH_DR: nxt_tap = tms_s ? TS_EX1_DR : TS_SH_DR;
        TS_EX1_DR: nxt_tap = tms_s ? TS_UPD_DR : TS_PAU_DR;
        TS_PAU_DR: nxt_tap = tms_s ? TS_EX2_DR : TS_PAU_DR;
        TS_EX2_DR: nxt_tap = tms_s ? TS_UPD_DR : TS_SH_DR;
        TS_UPD_DR: nxt_tap = tms_s ? TS_SEL_DR : TS_IDLE;
        TS_SEL_IR: nxt_tap = tms_s ? TS_RESET : TS_CAP_IR;
        TS_CAP_IR: nxt_tap = tms_s ? TS_EX1_IR : TS_SH_IR;
        TS_SH_IR: nxt_tap = tms_s ? TS_EX1_IR : TS_SH_IR;
        TS_EX1_IR: nxt_tap = tms_s ? TS_UPD_IR : TS_PAU_IR;
        TS_PAU_IR: nxt_tap = tms_s ? TS_EX2_IR : TS_PAU_IR;
        TS_EX2_IR: nxt_tap = tms_s ? TS_UPD_IR : TS_SH_IR;
        TS_UPD_IR: nxt_tap = tms_s ? TS_SEL_DR : TS_IDLE;
        default: nxt_tap = TS_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction and data shift paths, execution
  logic [IR_W-1:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
  logic [DR_W-1:0] dr_ff, nxt_dr;
  logic [PUBKEY_W-1:0] pubkey_ff, nxt_pubkey;
  logic null_ff, nxt_null, exec_done_ff, nxt_exec_done;
  logic tdo_ff, nxt_tdo, tdo_oe_ff, nxt_tdo_oe;
  logic nv_start_ff, nxt_nv_start, bridge_ff, nxt_bridge, jump_ff, nxt_jump;
  logic [OPND_W-1:0] boot_ff, nxt_boot;
  logic [1:0] width_ff, nxt_width;
  logic rel_r_ff, nxt_rel_r, rel_l_ff, nxt_rel_l;
  logic [SEC_BOOT_W-1:0] sec_ff, nxt_sec;
  logic busy_ff, nxt_busy, pend_nv_ff, nxt_pend_nv;
  logic [$clog2(RESTART_CYC+1)-1:0] rst_cnt_ff, nxt_rst_cnt;

  // Instructions whose data register captures read data
  function automatic logic is_read_op(input logic [IR_W-1:0] op);
    return (op == OP_PUBKEY_READ) || (op == OP_DRYRUN_SIG) || (op == OP_BUSY_POLL);
  endfunction : is_read_op

  always_comb begin
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    nxt_dr = dr_ff;
    nxt_pubkey = pubkey_ff;
    nxt_null = null_ff;
    nxt_exec_done = exec_done_ff;
    nxt_tdo = tdo_ff;
    nxt_tdo_oe = tdo_oe_ff;
    nxt_nv_start = 1'b0;
    nxt_jump = 1'b0;
    nxt_bridge = bridge_ff;
    nxt_boot = boot_ff;
    nxt_width = width_ff;
    nxt_rel_r = rel_r_ff;
    nxt_rel_l = rel_l_ff;
    nxt_sec = sec_ff;
    nxt_busy = busy_ff;
    nxt_pend_nv = pend_nv_ff;
    nxt_rst_cnt = (rst_cnt_ff != '0) ? rst_cnt_ff - 1'b1 : rst_cnt_ff;
    // Long operations end on the response from the store or flash side
    if (pend_nv_ff && nv_rsp.done) begin
      nxt_pend_nv = 1'b0;
      nxt_pubkey = nv_prog_data;
      nxt_busy = bridge_ff;
    end
    if (bridge_ff && nv_rsp.done && !pend_nv_ff) begin
      nxt_bridge = 1'b0;
      nxt_busy = 1'b0;
    end
    if (tck_fall) begin
      nxt_tdo_oe = (tap_ff == TS_SH_DR) || (tap_ff == TS_SH_IR);
      nxt_tdo = (tap_ff == TS_SH_IR) ? ir_sh_ff[0] : dr_ff[0];
    end
    if (tck_rise) begin
      case (tap_ff)
        TS_RESET: begin
          nxt_ir = IR_RST;
          nxt_null = 1'b0;
        end
        TS_CAP_IR: nxt_ir_sh = {{(IR_W-2){1'b0}}, 2'h1};
        TS_SH_IR: nxt_ir_sh = {tdi_s, ir_sh_ff[IR_W-1:1]};
        TS_UPD_IR: begin
          nxt_ir = ir_sh_ff;
          nxt_null = nullify;
          nxt_exec_done = 1'b0;
        end
        TS_CAP_DR: begin
          // Nullified: no capture, register left as is
          if (!null_ff) begin
            case (ir_ff)
              OP_PUBKEY_READ: nxt_dr = pubkey_ff;
              OP_DRYRUN_SIG: nxt_dr = dryrun_sig;
              OP_BUSY_POLL: nxt_dr = {{(DR_W-1){1'b0}}, busy_ff};
              default: nxt_dr = dr_ff;
            endcase
          end
        end
        // Shift stays live even when nullified
        TS_SH_DR: nxt_dr = {tdi_s, dr_ff[DR_W-1:1]};
        TS_UPD_DR: nxt_exec_done = 1'b0;
        TS_IDLE: begin
          // Refused command is dropped, so it cannot fire on a later rise
          if (busy_ff) begin
            nxt_exec_done = 1'b1;
          end
          // One execution per visit to Run-Test/Idle, refused while busy
          if (!exec_done_ff && !null_ff && !busy_ff && !is_read_op(ir_ff)) begin
            nxt_exec_done = 1'b1;
            case (ir_ff)
              OP_JUMP: begin
                nxt_boot = dr_ff[OPND_W-1:0];
                nxt_jump = 1'b1;
              end
              OP_FLASH_BRIDGE: begin
                nxt_bridge = 1'b1;
                nxt_busy = 1'b1;
              end
              OP_PORT_WIDTH: nxt_width = dr_ff[WIDTH_LSB +: 2];
              OP_BANK_RELEASE: begin
                nxt_rel_r = rel_r_ff | dr_ff[BANK_RIGHT_BIT];
                nxt_rel_l = rel_l_ff | dr_ff[BANK_LEFT_BIT];
              end
              OP_PUBKEY_PROG: begin
                nxt_nv_start = 1'b1;
                nxt_pend_nv = 1'b1;
                nxt_busy = 1'b1;
              end
              OP_SEC_BOOT: nxt_sec = dr_ff[SEC_BOOT_W-1:0];
              OP_RESTART: nxt_rst_cnt = ($clog2(RESTART_CYC+1))'(RESTART_CYC);
              default: nxt_exec_done = 1'b1;
            endcase
          end
        end
        default: nxt_ir_sh = ir_sh_ff;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tap_ff <= TS_RESET;
      ir_sh_ff <= '0;
      ir_ff <= IR_RST;
      dr_ff <= '0;
      pubkey_ff <= '0;
      null_ff <= 1'b0;
      exec_done_ff <= 1'b0;
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
      nv_start_ff <= 1'b0;
      bridge_ff <= 1'b0;
      jump_ff <= 1'b0;
      boot_ff <= '0;
      width_ff <= WIDTH_SINGLE;
      rel_r_ff <= 1'b0;
      rel_l_ff <= 1'b0;
      sec_ff <= SEC_BOOT_RST;
      busy_ff <= 1'b0;
      pend_nv_ff <= 1'b0;
      rst_cnt_ff <= '0;
      nv_prog_data <= '0;
      restart_req <= 1'b0;
    end else begin
      tap_ff <= nxt_tap;
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
      dr_ff <= nxt_dr;
      pubkey_ff <= nxt_pubkey;
      null_ff <= nxt_null;
      exec_done_ff <= nxt_exec_done;
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
      nv_start_ff <= nxt_nv_start;
      bridge_ff <= nxt_bridge;
      jump_ff <= nxt_jump;
      boot_ff <= nxt_boot;
      width_ff <= nxt_width;
      rel_r_ff <= nxt_rel_r;
      rel_l_ff <= nxt_rel_l;
      sec_ff <= nxt_sec;
      busy_ff <= nxt_busy;
      pend_nv_ff <= nxt_pend_nv;
      rst_cnt_ff <= nxt_rst_cnt;
      if (nxt_nv_start) begin
        nv_prog_data <= dr_ff;
      end
      restart_req <= (nxt_rst_cnt != '0);
    end
  end

  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;
  assign nv_prog_start = nv_start_ff;
  assign flash_bridge_en = bridge_ff;
  assign boot_addr = boot_ff;
  assign boot_jump = jump_ff;
  assign serial_port_width = width_ff;
  assign bank_right_release = rel_r_ff;
  assign bank_left_release = rel_l_ff;
  assign sec_boot_addr = sec_ff;
  assign busy = busy_ff;
endmodule : ccd_decoder

/* verif/ccd_nv_model.sv */
// Behavioural nonvolatile store and flash answering delayed operations
`timescale 1ns/100ps
module ccd_nv_model #(
  parameter int DELAY = 2000
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic nv_prog_start,
  input wire logic flash_bridge_en,
  output ccd_pkg::ccd_nv_rsp_s nv_rsp
);
  import ccd_pkg::*;
  int cnt_ff, nxt_cnt;
  logic fb_ff, done_ff, nxt_done;
  logic [PUBKEY_W-1:0] pat_ff, nxt_pat;
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    // Data is unused, so it toggles rather than looking valid
    nxt_pat = ~pat_ff;
    if (nv_prog_start || (flash_bridge_en && !fb_ff)) begin
      nxt_cnt = DELAY;
    end else if (cnt_ff == 1) begin
      nxt_cnt = 0;
      nxt_done = 1'b1;
    end else if (cnt_ff != 0) begin
      nxt_cnt = cnt_ff - 1;
    end
  end
  always_ff @(posedge clock) begin
    cnt_ff <= rst ? 0 : nxt_cnt;
    done_ff <= rst ? 1'b0 : nxt_done;
    fb_ff <= rst ? 1'b0 : flash_bridge_en;
    pat_ff <= rst ? 32'h5555_aaaa : nxt_pat;
  end
  assign nv_rsp = '{done: done_ff, data: pat_ff};
endmodule : ccd_nv_model

/* verif/ccd_decoder_sva.sv */
// Assertion checker for the configuration command decoder
`timescale 1ns/100ps
module ccd_decoder_chk (
  input wire logic clock,
  input wire logic rst,
  input wire ccd_pkg::ccd_tap_in_s tap_in,
  input wire ccd_pkg::ccd_nv_rsp_s nv_rsp,
  input wire logic nv_prog_start,
  input wire logic flash_bridge_en,
  input wire logic [ccd_pkg::OPND_W-1:0] boot_addr,
  input wire logic boot_jump,
  input wire logic bank_right_release,
  input wire logic bank_left_release,
  input wire logic restart_req,
  input wire logic busy
);
  import ccd_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_jump_pulse; boot_jump |=> !boot_jump; endproperty
  a_jump_pulse: assert property (p_jump_pulse) else $error("jump pulse too long");
  property p_addr_jump; $changed(boot_addr) |-> boot_jump; endproperty
  a_addr_jump: assert property (p_addr_jump) else $error("address moved without jump");
  // Execution follows a test clock rise through the synchroniser
  property p_exec_tck; boot_jump |-> $past(tap_in.tck, 3); endproperty
  a_exec_tck: assert property (p_exec_tck) else $error("jump without tck rise");
  property p_bridge_hold; flash_bridge_en && !nv_rsp.done |=> flash_bridge_en; endproperty
  a_bridge_hold: assert property (p_bridge_hold) else $error("bridge dropped early");
  property p_right_sticky; bank_right_release |=> bank_right_release; endproperty
  a_right_sticky: assert property (p_right_sticky) else $error("right release lost");
  property p_left_sticky; bank_left_release |=> bank_left_release; endproperty
  a_left_sticky: assert property (p_left_sticky) else $error("left release lost");
  property p_start_busy; nv_prog_start |-> ##[0:1] busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_busy_hold; busy && !nv_rsp.done |=> busy; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_no_start_busy; nv_prog_start |-> !$past(busy); endproperty
  a_no_start_busy: assert property (p_no_start_busy) else $error("start while busy");
  property p_restart_len; $rose(restart_req) |-> restart_req[*5] ##1 !restart_req; endproperty
  a_restart_len: assert property (p_restart_len) else $error("restart length");
endmodule : ccd_decoder_chk
bind ccd_decoder ccd_decoder_chk u_chk (.clock(clock), .rst(rst), .tap_in(tap_in),
  .nv_rsp(nv_rsp), .nv_prog_start(nv_prog_start), .flash_bridge_en(flash_bridge_en),
  .boot_addr(boot_addr), .boot_jump(boot_jump), .bank_right_release(bank_right_release),
  .bank_left_release(bank_left_release), .restart_req(restart_req), .busy(busy));

/* verif/ccd_decoder_tb_top.sv */
// Self-checking testbench for the configuration command decoder
`timescale 1ns/100ps
module ccd_decoder_tb_top;
  import ccd_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  ccd_tap_in_s tap = '0;
  logic nullify = 1'b0;
  logic [31:0] sig = 32'h5a3c_0f96;
  ccd_nv_rsp_s nv_rsp;
  logic tdo, tdo_oe, nv_prog_start, flash_bridge_en, boot_jump, restart_req, busy, brr, blr;
  logic [31:0] nv_prog_data, sec_boot_addr, rd;
  logic [23:0] boot_addr;
  logic [1:0] spw;
  logic oe_sh;
  int fail_count = 0;
  int tests_run = 0;
  int jumps = 0;
  int starts = 0;
  int rcyc = 0;
  initial begin
    forever #20 clock = ~clock;
  end
  ccd_decoder u_dut (.clock(clock), .rst(rst), .tap_in(tap), .tdo(tdo), .tdo_oe(tdo_oe),
    .nullify(nullify), .dryrun_sig(sig), .nv_rsp(nv_rsp), .nv_prog_start(nv_prog_start),
    .nv_prog_data(nv_prog_data), .flash_bridge_en(flash_bridge_en), .boot_addr(boot_addr),
    .boot_jump(boot_jump), .serial_port_width(spw), .bank_right_release(brr),
    .bank_left_release(blr), .sec_boot_addr(sec_boot_addr), .restart_req(restart_req),
    .busy(busy));
  ccd_nv_model #(.DELAY(2000)) u_nv (.clock(clock), .rst(rst), .nv_prog_start(nv_prog_start),
    .flash_bridge_en(flash_bridge_en), .nv_rsp(nv_rsp));
  always @(posedge clock) begin
    if (boot_jump) jumps <= jumps + 1;
    if (nv_prog_start) starts <= starts + 1;
    if (restart_req) rcyc <= rcyc + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One test clock period of eight system clocks; tdo read before the rise
  task automatic tbit(input logic m, input logic d, output logic q);
    tap.tck <= 1'b0;
    tap.tms <= m;
    tap.tdi <= d;
    repeat (5) @(posedge clock);
    q = tdo;
    tap.tck <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : tbit
  task automatic cmd(input logic [7:0] op, input logic [31:0] d, input logic nul,
                     output logic [31:0] r);
    logic q;
    nullify <= nul;
    for (int i = 0; i < 4; i++) tbit(i < 2, 1'b0, q);
    for (int i = 0; i < 8; i++) tbit(i == 7, op[i], q);
    for (int i = 0; i < 4; i++) tbit(i < 2, 1'b0, q);
    for (int i = 0; i < 32; i++) begin
      tbit(i == 31, d[i], q);
      r[i] = q;
      if (i == 16) oe_sh = tdo_oe;
    end
    // Update-DR, Idle, then the executing rise
    for (int i = 0; i < 3; i++) tbit(i == 0, 1'b0, q);
    repeat (3) @(posedge clock);
  endtask : cmd
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_jump_null;
    cmd(OP_JUMP, 32'hff12_3456, 1'b0, rd);
    chk(boot_addr, 32'h12_3456);
    chk(oe_sh, 1'b1);
    chk(tdo_oe, 1'b0);
    cmd(OP_JUMP, 32'h00ab_cdef, 1'b1, rd);
    chk(boot_addr, 32'h12_3456);
    chk(jumps, 1);
  endtask : t_jump_null
  task automatic t_config;
    logic [1:0] w [3] = '{WIDTH_DUAL, WIDTH_QUAD, WIDTH_SINGLE};
    for (int i = 0; i < 3; i++) begin
      cmd(OP_PORT_WIDTH, {30'h0, w[i]}, 1'b0, rd);
      chk(spw, w[i]);
    end
    cmd(OP_BANK_RELEASE, 32'h2, 1'b0, rd);
    chk({brr, blr}, 2'b10);
    cmd(OP_BANK_RELEASE, 32'h1, 1'b0, rd);
    chk({brr, blr}, 2'b11);
    cmd(OP_SEC_BOOT, 32'hc0de_1234, 1'b0, rd);
    chk(sec_boot_addr, 32'hc0de_1234);
    cmd(OP_DRYRUN_SIG, 32'h0, 1'b0, rd);
    chk(rd, 32'h5a3c_0f96);
  endtask : t_config
  task automatic t_pubkey;
    cmd(OP_PUBKEY_PROG, 32'h0bad_f00d, 1'b0, rd);
    chk(starts, 1);
    chk(nv_prog_data, 32'h0bad_f00d);
    chk(busy, 1'b1);
    cmd(OP_BUSY_POLL, 32'h0, 1'b0, rd);
    chk(rd[0], 1'b1);
    // Refused while the key is still being written
    cmd(OP_JUMP, 32'h77, 1'b0, rd);
    chk(boot_addr, 32'h12_3456);
    // Idle long enough for busy to clear before the next scan starts
    repeat (1500) @(posedge clock);
    rd = '1;
    for (int i = 0; i < 8 && rd[0] !== 1'b0; i++) cmd(OP_BUSY_POLL, 32'h0, 1'b0, rd);
    chk(rd[0], 1'b0);
    chk(boot_addr, 32'h12_3456);
    chk(jumps, 1);
    cmd(OP_PUBKEY_READ, 32'h0, 1'b0, rd);
    chk(rd, 32'h0bad_f00d);
  endtask : t_pubkey
  task automatic t_bridge_restart;
    cmd(OP_FLASH_BRIDGE, 32'h0, 1'b0, rd);
    chk(flash_bridge_en, 1'b1);
    chk(busy, 1'b1);
    for (int i = 0; i < 3000 && flash_bridge_en; i++) @(posedge clock);
    chk(flash_bridge_en, 1'b0);
    chk(busy, 1'b0);
    cmd(OP_RESTART, 32'h0, 1'b0, rd);
    repeat (8) @(posedge clock);
    chk(rcyc, 5);
  endtask : t_bridge_restart
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    tbit(1'b0, 1'b0, rd[0]);
    t_jump_null();
    t_config();
    t_pubkey();
    t_bridge_restart();
    final_report();
  end
endmodule : ccd_decoder_tb_top
